// *** common/uart_flow_pkg.sv ***
package uart_flow_pkg;
  // Register bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte addresses.
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_WMARK = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_XFCR = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CHARS = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h10;
  // Bit positions in the serial control register.
  localparam int CTRL_RTS_BIT = 0;
  localparam int CTRL_CTS_BIT = 1;
  localparam int CTRL_PORT_BIT = 2;
  // Bit positions in the extended flow control register.
  localparam int XFCR_EN_BIT = 0;
  localparam int XFCR_MODE_LSB = 1;
  // Byte lanes of the character register.
  localparam int CH_RESUME1_LSB = 0;
  localparam int CH_STOP1_LSB = 8;
  localparam int CH_RESUME2_LSB = 16;
  localparam int CH_STOP2_LSB = 24;
  // Reset values.
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [2:0] XFCR_RESET = 3'h0;
  localparam logic [31:0] CHARS_RESET = 32'h13111311;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Software receive flow mode encodings.
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_FIRST = 2'h1,
    MODE_SECOND = 2'h2,
    MODE_BOTH = 2'h3
  } soft_mode_t;
  // Transmit gate states.
  typedef enum logic {TX_IDLE, TX_BUSY} tx_state_t;
endpackage

// *** design/uart_flow_control.sv ***
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
// Function
// - Separate enables for request and clear to send.
// - Request asserted while receive level below watermark.
// - Request reasserted once reads drop below watermark.
// - Without request flow, receive until full.
// - Check clear to send before each character.
// - Send back to back; nothing when empty.
// - Finish current character when clear drops.
// - Without clear flow, ignore pin entirely; the status register still reports it.
// - Software enable bit gates all software flow.
// - Compare every received character with stop values.
// - Mode selects single or two sequential stops.
// - Mode 01 first pair, 10 second pair.
module uart_flow_control
  import uart_flow_pkg::*;
#(
  parameter int LEVEL_W = 5
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [LEVEL_W-1:0] rx_fifo_level,
  input wire logic tx_fifo_empty,
  input wire logic tx_char_done,
  output logic tx_start,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  output logic rx_char_ready,
  output logic rx_out_valid,
  output logic [7:0] rx_out_data,
  input wire logic rx_out_ready,
  input wire logic clear_to_send_in_n,
  output logic req_to_send_out_n
);

  // The level compare needs at least one bit, and the watermark must fit one bus word.
  if (LEVEL_W < 1 || LEVEL_W > DATA_W) $error("LEVEL_W must be 1 to DATA_W bits wide.");

  // Registers and bus state.
  logic [2:0] serial_control_register, next_ctrl;
  logic [LEVEL_W-1:0] watermark, next_watermark;
  logic [2:0] extended_flow_control_register, next_xfcr;
  logic [31:0] flow_chars, next_chars;
  logic aw_held, next_aw_held; // Write address taken, waiting for data.
  logic w_held, next_w_held; // Write data taken, waiting for address.
  logic [ADDR_W-1:0] wr_addr, next_wr_addr;
  logic [31:0] wr_data, next_wr_data;
  logic [3:0] wr_strb, next_wr_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [31:0] lane_mask; // Byte enables widened to bits.
  // Flow state.
  logic cts_meta, cts_sync; // Two-stage synchroniser for the pin.
  tx_state_t tx_state, next_tx_state;
  logic next_tx_start, next_rts_n;
  logic paused, next_paused; // Transmitter held by a stop character.
  logic seen_stop1, next_seen_stop1; // Last character was the first stop.
  logic seen_resume1, next_seen_resume1; // Last character was the first resume.
  logic [7:0] head, next_head, tail, next_tail; // Two-entry buffer.
  logic [1:0] count, next_count;
  logic next_in_ready, next_out_valid;

  // Convenience decodes of the control fields.
  logic rts_en, cts_en, port_en, soft_en;
  soft_mode_t mode;
  logic [7:0] resume1, stop1, resume2, stop2;
  assign rts_en = serial_control_register[CTRL_RTS_BIT];
  assign cts_en = serial_control_register[CTRL_CTS_BIT];
  assign port_en = serial_control_register[CTRL_PORT_BIT];
  assign soft_en = extended_flow_control_register[XFCR_EN_BIT];
  assign mode = soft_mode_t'(extended_flow_control_register[XFCR_MODE_LSB +: 2]);
  assign resume1 = flow_chars[CH_RESUME1_LSB +: 8];
  assign stop1 = flow_chars[CH_STOP1_LSB +: 8];
  assign resume2 = flow_chars[CH_RESUME2_LSB +: 8];
  assign stop2 = flow_chars[CH_STOP2_LSB +: 8];
  assign lane_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // Register bus: address and data are taken in either order, the write
  // happens one cycle after both are held, and one read is served at a time.
  always_comb
  begin
    next_ctrl = serial_control_register;
    next_watermark = watermark;
    next_xfcr = extended_flow_control_register;
    next_chars = flow_chars;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_wr_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_wr_data = s_axi_wdata;
      next_wr_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    // Both halves held: commit the write and answer.
    if (aw_held && w_held)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      unique case (wr_addr)
        ADDR_CTRL: next_ctrl = (serial_control_register & ~lane_mask[2:0])
          | (wr_data[2:0] & lane_mask[2:0]);
        ADDR_WMARK: next_watermark = (watermark & ~lane_mask[LEVEL_W-1:0])
          | (wr_data[LEVEL_W-1:0] & lane_mask[LEVEL_W-1:0]);
        ADDR_XFCR: next_xfcr = (extended_flow_control_register & ~lane_mask[2:0])
          | (wr_data[2:0] & lane_mask[2:0]);
        ADDR_CHARS: next_chars = (flow_chars & ~lane_mask) | (wr_data & lane_mask);
        ADDR_STAT: next_bresp = RESP_OKAY; // Status is read-only; writes are dropped.
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
    // Read data is captured when the address is taken.
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0;
      unique case (s_axi_araddr)
        ADDR_CTRL: next_rdata[2:0] = serial_control_register;
        ADDR_WMARK: next_rdata[LEVEL_W-1:0] = watermark;
        ADDR_XFCR: next_rdata[2:0] = extended_flow_control_register;
        ADDR_CHARS: next_rdata = flow_chars;
        ADDR_STAT: next_rdata[3:0] = {req_to_send_out_n, ~cts_sync, paused,
          tx_state == TX_BUSY};
        default: next_rresp = RESP_SLVERR;
      endcase
    end
    // Readies are flops, so they look one cycle ahead.
    next_awready = !next_aw_held && !next_bvalid && !(aw_held && w_held);
    next_wready = !next_w_held && !next_bvalid && !(aw_held && w_held);
    next_arready = !next_rvalid;
  end

  // Register the bus and register-file state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      serial_control_register <= CTRL_RESET;
      watermark <= '1;
      extended_flow_control_register <= XFCR_RESET;
      flow_chars <= CHARS_RESET;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
    end
    else
    begin
      serial_control_register <= next_ctrl;
      watermark <= next_watermark;
      extended_flow_control_register <= next_xfcr;
      flow_chars <= next_chars;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // Flow logic: request line, transmit gate, stop matching and the buffer.
  logic push, pop, start_ok, soft_on;
  always_comb
  begin
    push = rx_char_valid && rx_char_ready;
    pop = rx_out_valid && rx_out_ready;
    soft_on = soft_en && (mode != MODE_OFF);
    // Request stays low (asserted) while the level is under the mark. When
    // request flow is off it stays asserted and the receiver fills freely.
    next_rts_n = rts_en && (rx_fifo_level >= watermark);
    // The pin is sampled only between characters, never mid-character.
    start_ok = port_en && !tx_fifo_empty && !paused
      && (!cts_en || !cts_sync);
    next_tx_state = tx_state;
    next_tx_start = 1'b0;
    unique case (tx_state)
      TX_IDLE:
        if (start_ok)
        begin
          next_tx_start = 1'b1;
          next_tx_state = TX_BUSY;
        end
      TX_BUSY:
        if (tx_char_done)
        begin
          next_tx_state = TX_IDLE;
        end
    endcase
    // Stop and resume matching on every accepted character.
    next_paused = paused;
    next_seen_stop1 = seen_stop1;
    next_seen_resume1 = seen_resume1;
    if (!soft_on)
    begin
      next_paused = 1'b0;
      next_seen_stop1 = 1'b0;
      next_seen_resume1 = 1'b0;
    end
    else if (push)
    begin
      next_seen_stop1 = rx_char_data == stop1;
      next_seen_resume1 = rx_char_data == resume1;
      unique case (mode)
        MODE_FIRST:
        begin
          if (rx_char_data == stop1) next_paused = 1'b1;
          else if (rx_char_data == resume1) next_paused = 1'b0;
        end
        MODE_SECOND:
        begin
          if (rx_char_data == stop2) next_paused = 1'b1;
          else if (rx_char_data == resume2) next_paused = 1'b0;
        end
        MODE_BOTH:
        begin
          if (seen_stop1 && rx_char_data == stop2) next_paused = 1'b1;
          else if (seen_resume1 && rx_char_data == resume2) next_paused = 1'b0;
        end
        MODE_OFF: next_paused = 1'b0;
      endcase
    end
    // Two-entry buffer with the head always in one flop.
    next_head = head;
    next_tail = tail;
    next_count = count;
    unique case ({push, pop})
      2'b10:
      begin
        if (count == 2'h0) next_head = rx_char_data;
        else next_tail = rx_char_data;
        next_count = count + 2'h1;
      end
      2'b01:
      begin
        next_head = tail;
        next_count = count - 2'h1;
      end
      2'b11:
      begin
        if (count == 2'h1) next_head = rx_char_data;
        else
        begin
          next_head = tail;
          next_tail = rx_char_data;
        end
      end
      2'b00: next_count = count;
    endcase
    next_in_ready = next_count != 2'h2;
    next_out_valid = next_count != 2'h0;
  end

  // Register the flow state; the pin passes two flops first.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cts_meta <= 1'b1;
      cts_sync <= 1'b1;
      req_to_send_out_n <= 1'b0;
      tx_state <= TX_IDLE;
      tx_start <= 1'b0;
      paused <= 1'b0;
      seen_stop1 <= 1'b0;
      seen_resume1 <= 1'b0;
      head <= 8'h0;
      tail <= 8'h0;
      count <= 2'h0;
      rx_char_ready <= 1'b0;
      rx_out_valid <= 1'b0;
      rx_out_data <= 8'h0;
    end
    else
    begin
      cts_meta <= clear_to_send_in_n;
      cts_sync <= cts_meta;
      req_to_send_out_n <= next_rts_n;
      tx_state <= next_tx_state;
      tx_start <= next_tx_start;
      paused <= next_paused;
      seen_stop1 <= next_seen_stop1;
      seen_resume1 <= next_seen_resume1;
      head <= next_head;
      tail <= next_tail;
      count <= next_count;
      rx_char_ready <= next_in_ready;
      rx_out_valid <= next_out_valid;
      rx_out_data <= next_head;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rts_at_mark: assert property (rts_en && rx_fifo_level >= watermark |=> req_to_send_out_n)
    else $error("Request not released at watermark.");
  a_rts_below_mark: assert property (rx_fifo_level < watermark |=> !req_to_send_out_n)
    else $error("Request not asserted below watermark.");
  a_rts_flow_off: assert property (!rts_en |=> !req_to_send_out_n)
    else $error("Request released with its flow control off.");
  a_cts_gate: assert property (tx_start && $past(cts_en) |-> !$past(cts_sync))
    else $error("Character started while clear to send was high.");
  a_empty_no_start: assert property (tx_start |-> !$past(tx_fifo_empty))
    else $error("Character started from an empty transmit queue.");
  a_busy_holds: assert property (tx_state == TX_BUSY && !tx_char_done |=> !tx_start
    && tx_state == TX_BUSY)
    else $error("Transmit gate left a character early.");
  a_soft_gate: assert property (!soft_en |=> !paused)
    else $error("Software pause active with software flow disabled.");
  a_stop_pause: assert property (push && soft_en && mode == MODE_FIRST
    && rx_char_data == stop1 |=> paused ##1 !tx_start)
    else $error("First stop character did not pause the transmitter.");
  a_buf_hold: assert property (rx_out_valid && !rx_out_ready |=> rx_out_valid
    && $stable(rx_out_data))
    else $error("Buffered character dropped under stall.");

endmodule

// *** test/uart_far_port.sv ***
`timescale 1ns/1ps
// Far serial port: drives our clear-to-send pin, paces our transmitter and sends us bytes.
module uart_far_port #(
  parameter int CHAR_CYC = 6
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req_to_send_out_n,
  input wire logic tx_start,
  input wire logic remote_full,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic rx_char_ready,
  output logic clear_to_send_in_n,
  output logic tx_char_done,
  output logic rx_char_valid,
  output logic [7:0] rx_char_data,
  output logic idle,
  output int tx_count,
  output int overlap
);
  logic [7:0] tcnt; // Cycles left of the byte the device is sending us.
  logic [7:0] rcnt; // Cycles left of the byte we are sending.
  logic [7:0] hold; // Byte waiting to be sent.
  logic pend; // A byte is waiting or on the wire.
  // A full remote buffer deasserts the pin, which means driving it high.
  assign clear_to_send_in_n = remote_full;
  // Outside a valid byte the data shows the inverse, so a stale byte never passes.
  assign rx_char_data = rx_char_valid ? hold : ~hold;
  assign idle = !pend;
  // Byte timing in both directions.
  always_ff @(posedge aclk)
  begin
    tx_char_done <= 1'b0;
    if (!aresetn)
    begin
      tcnt <= 8'h00;
      rcnt <= 8'h00;
      hold <= 8'h00;
      pend <= 1'b0;
      rx_char_valid <= 1'b0;
      tx_count <= 0;
      overlap <= 0;
    end
    else
    begin
      // A start during a byte would cut that byte short.
      if (tx_start)
      begin
        overlap <= overlap + ((tcnt != 8'h00) ? 1 : 0);
        tcnt <= 8'(CHAR_CYC);
        tx_count <= tx_count + 1;
      end
      else if (tcnt == 8'h01)
      begin
        tcnt <= 8'h00;
        tx_char_done <= 1'b1;
      end
      else if (tcnt != 8'h00)
        tcnt <= tcnt - 8'h01;
      if (push)
      begin
        pend <= 1'b1;
        hold <= push_data;
      end
      // A byte starts only while the device requests; one begun is finished.
      if (pend && rcnt == 8'h00 && !rx_char_valid && !req_to_send_out_n)
        rcnt <= 8'(CHAR_CYC);
      else if (rcnt == 8'h01)
      begin
        rcnt <= 8'h00;
        rx_char_valid <= 1'b1;
      end
      else if (rcnt != 8'h00)
        rcnt <= rcnt - 8'h01;
      if (rx_char_valid && rx_char_ready)
      begin
        rx_char_valid <= 1'b0;
        pend <= 1'b0;
      end
    end
  end
endmodule

// *** test/uart_flow_control_test.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module uart_flow_control_test;
  import uart_flow_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, done, start, cv, cr, ov, cts_n, rts_n, idle;
  logic [1:0] bresp, rresp;
  logic [4:0] level = 5'h00; // Receive buffer fill seen by the block.
  logic tx_empty = 1'b1, ordy = 1'b1, full = 1'b0, push = 1'b0;
  logic [7:0] pdata = 8'h00, cd, od;
  int errors = 0, check_count = 0, cyc = 0, seed = 89, tx_count, overlap;
  logic [7:0] exp_q[$]; // Bytes expected at the receive output, in order.
  // Each entry is {enable, mode, first byte, second byte}.
  logic [18:0] cases [8] = '{19'h11300, 19'h50013, 19'h51311, 19'h61300,
    19'h600a5, 19'h713a5, 19'h71300, 19'h4a513};
  uart_flow_control #(.LEVEL_W(5)) uart_flow_control_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_fifo_level(level), .tx_fifo_empty(tx_empty), .tx_char_done(done), .tx_start(start),
    .rx_char_valid(cv), .rx_char_data(cd), .rx_char_ready(cr), .rx_out_valid(ov),
    .rx_out_data(od), .rx_out_ready(ordy), .clear_to_send_in_n(cts_n),
    .req_to_send_out_n(rts_n));
  uart_far_port #(.CHAR_CYC(6)) uart_far_port_inst (.aclk(aclk), .aresetn(aresetn),
    .req_to_send_out_n(rts_n), .tx_start(start), .remote_full(full), .push(push),
    .push_data(pdata), .rx_char_ready(cr), .clear_to_send_in_n(cts_n), .tx_char_done(done),
    .rx_char_valid(cv), .rx_char_data(cd), .idle(idle), .tx_count(tx_count),
    .overlap(overlap));
  always #10 aclk = ~aclk;
  // Prints the verdict and stops the run.
  task automatic end_sim();
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Register write; address and data are released each when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", RESP_OKAY, bresp)
    // Let an edge pass so a following call never reassigns bready in this step.
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // Let an edge pass so a following call never reassigns rready in this step.
    @(posedge aclk);
  endtask
  // Hands one byte to the far port and waits until the block has taken it.
  task automatic send(input logic [7:0] c);
    push <= 1'b1;
    pdata <= c;
    exp_q.push_back(c);
    @(posedge aclk);
    push <= 1'b0;
    @(posedge aclk);
    while (!idle)
      @(posedge aclk);
  endtask
  // Counts transmitter starts over a fixed window.
  task automatic moved(output int d);
    int c0;
    c0 = tx_count;
    tick(30);
    d = tx_count - c0;
  endtask
  function automatic logic exp_rts(logic en, logic [4:0] lv);
    return en && lv >= 5'h08;
  endfunction
  // Argument is {port, clear flow, remote full, transmit empty}.
  function automatic logic exp_move(logic [3:0] k);
    return k[3] && !k[0] && (!k[2] || !k[1]);
  endfunction
  // Stop and resume bytes here are 13/11 for the first pair and a5/5a for the second.
  function automatic logic exp_pause(logic [18:0] c);
    case (c[17:16])
      2'h1: return c[18] && (c[7:0] == 8'h13 || (c[15:8] == 8'h13 && c[7:0] != 8'h11));
      2'h2: return c[18] && (c[7:0] == 8'ha5 || (c[15:8] == 8'ha5 && c[7:0] != 8'h5a));
      2'h3: return c[18] && c[15:8] == 8'h13 && c[7:0] == 8'ha5;
      default: return 1'b0;
    endcase
  endfunction
  // Receive output scoreboard with a stalling sink, and the hang limit.
  always @(posedge aclk)
  begin
    cyc++;
    ordy <= cyc[1:0] != 2'h3;
    if (ov && ordy)
    begin
      `CHK("rx_out_data", exp_q[0], od)
      void'(exp_q.pop_front());
    end
    if (cyc == 20000)
    begin
      errors++;
      end_sim();
    end
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    int m;
    tick(4);
    aresetn <= 1'b1;
    tick(2);
    `CHK("rts_n_reset", 1'b0, rts_n)
    rd(ADDR_CTRL, d, r);
    `CHK("ctrl", CTRL_RESET, d[2:0])
    rd(ADDR_XFCR, d, r);
    `CHK("xfcr", XFCR_RESET, d[2:0])
    rd(ADDR_CHARS, d, r);
    `CHK("chars", CHARS_RESET, d)
    rd(8'h20, d, r);
    `CHK("unmapped", {RESP_SLVERR, 32'h0}, {r, d})
    wr(ADDR_WMARK, 32'h8);
    for (int i = 0; i < 40; i++)
    begin
      logic en;
      en = 1'((i / 10) % 2);
      if (i % 10 == 0)
        wr(ADDR_CTRL, {31'h0, en});
      level <= (i % 10 == 1) ? 5'h08 : (i % 10 == 2) ? 5'h07 : 5'($random(seed));
      tick(3);
      `CHK("rts_n", exp_rts(en, level), rts_n)
    end
    level <= 5'h1f;
    push <= 1'b1;
    pdata <= 8'h41;
    exp_q.push_back(8'h41);
    @(posedge aclk);
    push <= 1'b0;
    tick(30);
    `CHK("held_while_full", 1'b0, idle)
    level <= 5'h00;
    while (!idle)
      @(posedge aclk);
    for (int k = 0; k < 16; k++)
    begin
      wr(ADDR_CTRL, {29'h0, k[3], k[2], 1'b0});
      full <= k[1];
      tx_empty <= k[0];
      tick(20);
      moved(m);
      `CHK("tx_moving", exp_move(k[3:0]), m > 0)
    end
    wr(ADDR_CTRL, 32'h6);
    tx_empty <= 1'b0;
    for (int j = 0; j < 60; j++)
    begin
      full <= 1'($random(seed));
      tick(3);
    end
    full <= 1'b0;
    wr(ADDR_CTRL, 32'h4);
    wr(ADDR_CHARS, 32'ha55a1311);
    rd(ADDR_CHARS, d, r);
    `CHK("chars_rw", 32'ha55a1311, d)
    foreach (cases[j])
    begin
      wr(ADDR_XFCR, 32'h0);
      wr(ADDR_XFCR, {29'h0, cases[j][17:16], cases[j][18]});
      send(cases[j][15:8]);
      send(cases[j][7:0]);
      tick(20);
      moved(m);
      `CHK("paused", exp_pause(cases[j]), m == 0)
      rd(ADDR_STAT, d, r);
      `CHK("stat_resp", RESP_OKAY, r)
      `CHK("stat_paused", exp_pause(cases[j]), d[1])
      `CHK("stat_cts", 1'b1, d[2])
      `CHK("stat_rts", 1'b0, d[3])
    end
    tick(10);
    `CHK("overlap", 0, overlap)
    `CHK("rx_left", 0, exp_q.size())
    end_sim();
  end
endmodule
